// ==== design/pid_pkg.sv ====
// Shared constants and types for the loop compute block.
package pid_pkg;
    // -------------------------------------------------------------------
    // Number format
    // -------------------------------------------------------------------
    localparam int FRAC = 16;
    localparam int W = 32;
    localparam logic signed [31:0] ONE = 32'sh0001_0000;
    localparam logic signed [31:0] ZERO = 32'sh0000_0000;
    localparam logic [15:0] INTEGRAL_OFF = 16'h270F;
    localparam logic [15:0] DERIV_OFF = 16'h0000;
    localparam int SQRT_STEPS = 16;

    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_AUTO,
        MODE_CASCADE
    } loop_mode_t;

    typedef enum logic {
        TRANSFER_VARIANT_ONE,
        TRANSFER_VARIANT_TWO
    } transfer_t;
endpackage : pid_pkg

// ==== design/sqrt_unit.sv ====
// Combinational square root of a non-negative fixed-point value.
module sqrt_unit (
    input wire logic [31:0] value,
    output logic [31:0] root
);
    // Result keeps the 16-bit fraction: root(x * 2^16) = root(x) * 2^8.
    logic [47:0] rem;
    logic [31:0] res;
    logic [31:0] bitv;
    always_comb begin
        rem = {value, 16'h0000};
        res = 32'h0000_0000;
        bitv = 32'h0000_0000;
        for (int i = 23; i >= 0; i--) begin
            bitv = res | (32'h0000_0001 << i);
            if ({16'h0000, bitv} * {16'h0000, bitv} <= {16'h0000, rem}) begin
                res = bitv;
            end
        end
        root = res;
    end
endmodule : sqrt_unit

// ==== design/pid_loop_compute.sv ====
// One PID loop: error shaping, position/velocity control, modes, alarms.
//
// Behaviour
// - Bias step option rescales bias by setpoint ratio, clamped 0..1.
// - Integral time 9999 disables integral action; bias held for manual set.
// - Derivative time zero removes all derivative contribution.
// - Coefficients are gain times time ratios; zero gain drops the gain.
// - Velocity form outputs gain*de plus Ki*e minus derivative term.
// - Manual to automatic in position form loads bias=output; variant one also sets setpoint=PV.
// - Two bumpless transfer variants chosen by a setup input.
// - Four absolute PV alarms: above high limits, below low limits.
// - Two tiers of high and low deviation alarms against the setpoint.
// - Rate alarm when PV change per sample exceeds the rate limit.
// - Limit and deviation alarms set past threshold, with hysteresis band.
// - Manual passes external output but still evaluates all alarms.
// - Automatic computes output each sample and evaluates all alarms.
// - Cascade is automatic with setpoint taken from another loop's output.
// - Reverse action negates integral and proportional, adds PV derivative.
// - Square root option applies root to PV before use.
// - Error squaring: error times its absolute value, sign kept.
// - Deadband forces error to zero inside a symmetric band.
// - Squaring is applied before the deadband test.
// - Derivative limit filters PV; first or second differences by form.
// - Position form: bias accumulates integral; add P, subtract D of PV.
// - Position-form output clamped to nearer of 0.0 or 1.0.
// - Freeze option holds bias when computed output is out of range.
// - Default: on saturation bias becomes clamped output minus P and D.
module pid_loop_compute #(
    parameter int FRAC_BITS = pid_pkg::FRAC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic sample_tick,
    input wire logic [1:0] mode,
    input wire logic transfer_variant_two,
    input wire logic velocity_form,
    input wire logic reverse_acting,
    input wire logic freeze_bias,
    input wire logic bias_step,
    input wire logic sqrt_pv,
    input wire logic error_squared,
    input wire logic deadband_en,
    input wire logic deriv_limit_en,
    input wire logic [31:0] setpoint_in,
    input wire logic [31:0] cascade_setpoint,
    input wire logic [31:0] process_value,
    input wire logic [31:0] manual_output,
    input wire logic [31:0] proportional_gain,
    input wire logic [15:0] integral_time,
    input wire logic [15:0] derivative_time,
    input wire logic [15:0] sample_period,
    input wire logic [31:0] derivative_limit_coefficient,
    input wire logic [31:0] deadband,
    input wire logic bias_load,
    input wire logic [31:0] bias_load_value,
    input wire logic [31:0] limit_hh,
    input wire logic [31:0] limit_h,
    input wire logic [31:0] limit_l,
    input wire logic [31:0] limit_ll,
    input wire logic [31:0] dev_first,
    input wire logic [31:0] dev_second,
    input wire logic [31:0] rate_limit,
    input wire logic [31:0] hysteresis,
    output logic [31:0] control_output,
    output logic [31:0] bias_term,
    output logic [31:0] active_setpoint,
    output logic out_valid,
    output logic [9:0] alarms
);
    // The number helpers below assume the package's fraction width.
    if (FRAC_BITS != pid_pkg::FRAC) begin : g_frac_check
        $error("FRAC_BITS must match package fraction width.");
    end

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic signed [31:0] out;
        logic signed [31:0] bias;
        logic signed [31:0] sp;
        logic signed [31:0] sp_prev;
        logic signed [31:0] err_prev;
        logic signed [31:0] pv1;
        logic signed [31:0] pv2;
        logic signed [31:0] y1;
        logic signed [31:0] y2;
        logic [1:0] mode_prev;
        logic primed;
        logic valid;
        logic [9:0] alarm;
    } state_t;

    state_t st;
    state_t next_st;

    // Q16.16 product; the low fraction bits are truncated, not rounded.
    function automatic logic signed [31:0] fmul(
        input logic signed [31:0] a, input logic signed [31:0] b);
        logic signed [63:0] p;
        p = 64'(a) * 64'(b);
        return p[pid_pkg::FRAC +: 32];
    endfunction : fmul

    // Division by zero yields zero so a blank table entry cannot trap.
    function automatic logic signed [31:0] fdiv(
        input logic signed [31:0] a, input logic signed [31:0] b);
        logic signed [63:0] n;
        n = 64'(a) <<< pid_pkg::FRAC;
        if (b == pid_pkg::ZERO) begin
            return pid_pkg::ZERO;
        end
        return 32'(n / 64'(b));
    endfunction : fdiv

    function automatic logic signed [31:0] clamp01(
        input logic signed [31:0] v);
        if (v < pid_pkg::ZERO) begin
            return pid_pkg::ZERO;
        end
        if (v > pid_pkg::ONE) begin
            return pid_pkg::ONE;
        end
        return v;
    endfunction : clamp01

    function automatic logic signed [31:0] absv(
        input logic signed [31:0] v);
        return (v < pid_pkg::ZERO) ? -v : v;
    endfunction : absv

    // Alarm with hysteresis: set when past, clear only when back by hyst.
    function automatic logic hyst(input logic cur,
        input logic signed [31:0] excess, input logic signed [31:0] h);
        if (excess > pid_pkg::ZERO) begin
            return 1'b1;
        end
        if (cur && (excess > -h)) begin
            return 1'b1;
        end
        return 1'b0;
    endfunction : hyst

    logic [31:0] pv_root;
    sqrt_unit u_sqrt (
        .value(process_value),
        .root(pv_root)
    );

    // -------------------------------------------------------------------
    // Computation
    // -------------------------------------------------------------------
    logic signed [31:0] pv, sp_src, sp_use, diff, err, int_coef, der_coef;
    logic signed [31:0] period, int_time, der_time;
    logic signed [31:0] y, dy, d_term, p_term, bias_new, m, mc, base_bias;
    logic signed [31:0] dev;
    logic to_auto;

    always_comb begin
        next_st = st;
        // The enable low freezes the pulse along with all other state.
        if (clk_en) begin
            next_st.valid = 1'b0;
        end
        period = {16'h0000, sample_period};
        int_time = {16'h0000, integral_time};
        der_time = {16'h0000, derivative_time};
        pv = sqrt_pv ? signed'(pv_root) : signed'(process_value);
        sp_src = (mode == pid_pkg::MODE_CASCADE) ?
            signed'(cascade_setpoint) : signed'(setpoint_in);
        to_auto = (st.mode_prev == pid_pkg::MODE_MANUAL) &&
            (mode != pid_pkg::MODE_MANUAL);
        sp_use = sp_src;
        // Variant one tracks PV into setpoint; variant two keeps setpoint.
        if (to_auto && !velocity_form &&
            transfer_variant_two == pid_pkg::TRANSFER_VARIANT_ONE) begin
            sp_use = pv;
        end
        base_bias = st.bias;
        if (to_auto && !velocity_form) begin
            base_bias = st.out;
        end
        if (bias_load) begin
            base_bias = signed'(bias_load_value);
        end
        if (bias_step && st.primed && sp_use != st.sp_prev) begin
            base_bias = clamp01(reverse_acting ?
                fdiv(fmul(base_bias, st.sp_prev), sp_use) :
                fdiv(fmul(base_bias, sp_use), st.sp_prev));
        end
        diff = sp_use - pv;
        err = diff;
        if (error_squared) begin
            err = fmul(diff, absv(diff));
        end
        // The band is tested on the shaped error, so squaring comes first.
        if (deadband_en && absv(err) < signed'(deadband)) begin
            err = pid_pkg::ZERO;
        end
        // With zero gain the coefficients are the bare time ratios.
        int_coef = (integral_time == pid_pkg::INTEGRAL_OFF) ? pid_pkg::ZERO :
            fdiv(period, int_time);
        der_coef = fdiv(der_time, period);
        if (proportional_gain != 32'h0000_0000) begin
            int_coef = fmul(int_coef, proportional_gain);
            der_coef = fmul(der_coef, proportional_gain);
        end
        y = pv;
        // The filter starts once there is a previous sample to track.
        if (deriv_limit_en && st.primed) begin
            y = st.y1 + fmul(fdiv(period, period + fdiv(der_time,
                derivative_limit_coefficient)), pv - st.y1);
        end
        dy = velocity_form ? (y - st.y1 - st.y1 + st.y2) : (y - st.y1);
        if (!st.primed) begin
            dy = pid_pkg::ZERO;
        end
        d_term = (derivative_time == pid_pkg::DERIV_OFF) ? pid_pkg::ZERO :
            fmul(der_coef, dy);
        if (velocity_form) begin
            p_term = fmul(signed'(proportional_gain), err - st.err_prev);
            m = reverse_acting ? (-p_term - fmul(int_coef, err) + d_term) :
                (p_term + fmul(int_coef, err) - d_term);
            bias_new = base_bias;
        end else begin
            p_term = fmul(signed'(proportional_gain), err);
            bias_new = reverse_acting ? (base_bias - fmul(int_coef, err)) :
                (base_bias + fmul(int_coef, err));
            m = reverse_acting ? (-p_term + d_term + bias_new) :
                (p_term - d_term + bias_new);
        end
        mc = velocity_form ? m : clamp01(m);
        if (!velocity_form && m != mc) begin
            if (freeze_bias) begin
                bias_new = base_bias;
            end else begin
                bias_new = reverse_acting ? (mc + p_term - d_term) :
                    (mc - p_term + d_term);
            end
        end
        dev = pv - sp_use;
        if (clk_en && sample_tick) begin
            // History moves only with the output it produced.
            next_st.valid = 1'b1;
            next_st.mode_prev = mode;
            next_st.sp = sp_use;
            next_st.sp_prev = sp_use;
            // Manual keeps the bias; a position-form transfer reloads it from the output.
            if (mode == pid_pkg::MODE_MANUAL) begin
                next_st.out = signed'(manual_output);
                next_st.bias = base_bias;
            end else begin
                next_st.out = mc;
                next_st.bias = clamp01(bias_new);
            end
            next_st.err_prev = err;
            next_st.pv1 = pv;
            next_st.pv2 = st.pv1;
            next_st.y1 = y;
            next_st.y2 = st.y1;
            next_st.primed = 1'b1;
            // Alarms run in every mode.
            next_st.alarm[0] = hyst(st.alarm[0], pv - signed'(limit_hh),
                signed'(hysteresis));
            next_st.alarm[1] = hyst(st.alarm[1], pv - signed'(limit_h),
                signed'(hysteresis));
            next_st.alarm[2] = hyst(st.alarm[2], signed'(limit_l) - pv,
                signed'(hysteresis));
            next_st.alarm[3] = hyst(st.alarm[3], signed'(limit_ll) - pv,
                signed'(hysteresis));
            next_st.alarm[4] = hyst(st.alarm[4], dev - signed'(dev_first),
                signed'(hysteresis));
            next_st.alarm[5] = hyst(st.alarm[5], -dev - signed'(dev_first),
                signed'(hysteresis));
            next_st.alarm[6] = hyst(st.alarm[6], dev - signed'(dev_second),
                signed'(hysteresis));
            next_st.alarm[7] = hyst(st.alarm[7], -dev - signed'(dev_second),
                signed'(hysteresis));
            next_st.alarm[8] = st.primed &&
                (absv(pv - st.pv1) > signed'(rate_limit));
            next_st.alarm[9] = 1'b0;
        end
    end

    // Reset leaves mode_prev at manual, so the first automatic tick is a
    // bumpless transfer.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st <= '0;
            st.mode_prev <= pid_pkg::MODE_MANUAL;
        end else begin
            st <= next_st;
        end
    end

    assign control_output = st.out;
    assign bias_term = st.bias;
    assign active_setpoint = st.sp;
    assign out_valid = st.valid;
    assign alarms = st.alarm;
endmodule : pid_loop_compute

// ==== bench/pid_chk.sv ====
// Port assertions for the loop compute block.
module pid_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic sample_tick,
    input wire logic [1:0] mode,
    input wire logic transfer_variant_two,
    input wire logic velocity_form,
    input wire logic sqrt_pv,
    input wire logic [31:0] process_value,
    input wire logic [31:0] manual_output,
    input wire logic [31:0] cascade_setpoint,
    input wire logic [31:0] limit_hh,
    input wire logic [31:0] hysteresis,
    input wire logic [31:0] control_output,
    input wire logic [31:0] active_setpoint,
    input wire logic out_valid,
    input wire logic [9:0] alarms
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------------------
    // Properties
    // --------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire logic tk = clk_en && sample_tick;
    wire logic signed [31:0] pv = process_value;
    // The clear level sits one hysteresis band inside the high-high limit.
    wire logic signed [31:0] clr = $signed(limit_hh) - $signed(hysteresis);
    a_tick_answer: assert property (tk |=> out_valid)
        else $error("no answer after tick");
    a_valid_cause: assert property (clk_en && !sample_tick
        |=> !out_valid) else $error("answer without tick");
    a_valid_freeze: assert property (!clk_en |=> $stable(out_valid))
        else $error("pulse moved while disabled");
    a_output_hold: assert property (!tk |=> $stable(control_output)
        && $stable(alarms)) else $error("output moved without tick");
    a_manual_pass: assert property (tk && mode == 2'h0
        |=> control_output == $past(manual_output))
        else $error("manual output not passed");
    a_out_clamp: assert property (out_valid && !$past(velocity_form)
        |-> $signed(control_output) >= 0 && control_output <= pid_pkg::ONE)
        else $error("position output outside range");
    a_hh_set: assert property (tk && !sqrt_pv && pv > $signed(limit_hh)
        |=> alarms[0]) else $error("high-high alarm not set");
    a_hh_clear: assert property (tk && !sqrt_pv && pv < clr
        |=> !alarms[0]) else $error("high-high alarm not cleared");
    a_cascade_sp: assert property (tk && mode == 2'h2
        && transfer_variant_two |=> active_setpoint == $past(cascade_setpoint))
        else $error("cascade setpoint not used");
endmodule : pid_chk

// ==== bench/pv_source.sv ====
// Analog input stand-in that presents the process value to the loop.
module pv_source (
    input wire logic ref_clk,
    input wire logic [31:0] pv_set,
    output logic [31:0] process_value
);
    timeunit 1ns;
    timeprecision 100ps;
    // The converter updates on the falling edge, away from sampling.
    always @(negedge ref_clk) begin
        process_value <= pv_set;
    end
endmodule : pv_source

// ==== bench/pid_loop_compute_tb.sv ====
// Self-checking bench for the loop compute block.
module pid_loop_compute_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, resetn, clk_en, sample_tick, transfer_variant_two;
    logic velocity_form, reverse_acting, freeze_bias, bias_step, sqrt_pv;
    logic error_squared, deadband_en, deriv_limit_en, bias_load, out_valid;
    logic [1:0] mode;
    logic [9:0] alarms;
    logic [15:0] integral_time, derivative_time, sample_period;
    logic [31:0] setpoint_in, cascade_setpoint, process_value, pv_set;
    logic [31:0] manual_output, proportional_gain, bias_load_value;
    logic [31:0] derivative_limit_coefficient, deadband, dev_first;
    logic [31:0] limit_hh, limit_h, limit_l, limit_ll, dev_second;
    logic [31:0] rate_limit, hysteresis, control_output, bias_term;
    logic [31:0] active_setpoint;
    int n_mismatch, tests_run, cycles;
    pid_loop_compute dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .clk_en(clk_en), .sample_tick(sample_tick), .mode(mode),
        .transfer_variant_two(transfer_variant_two),
        .velocity_form(velocity_form), .reverse_acting(reverse_acting),
        .freeze_bias(freeze_bias), .bias_step(bias_step),
        .sqrt_pv(sqrt_pv), .error_squared(error_squared),
        .deadband_en(deadband_en), .deriv_limit_en(deriv_limit_en),
        .setpoint_in(setpoint_in), .cascade_setpoint(cascade_setpoint),
        .process_value(process_value), .manual_output(manual_output),
        .proportional_gain(proportional_gain),
        .integral_time(integral_time), .derivative_time(derivative_time),
        .sample_period(sample_period),
        .derivative_limit_coefficient(derivative_limit_coefficient),
        .deadband(deadband), .bias_load(bias_load),
        .bias_load_value(bias_load_value), .limit_hh(limit_hh),
        .limit_h(limit_h), .limit_l(limit_l), .limit_ll(limit_ll),
        .dev_first(dev_first), .dev_second(dev_second),
        .rate_limit(rate_limit), .hysteresis(hysteresis),
        .control_output(control_output), .bias_term(bias_term),
        .active_setpoint(active_setpoint), .out_valid(out_valid),
        .alarms(alarms));
    pv_source pv_u (.ref_clk(ref_clk), .pv_set(pv_set),
        .process_value(process_value));
    // --------------------
    // Helpers
    // --------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic tick();
        @(negedge ref_clk);
        sample_tick = 1'b1;
        @(posedge ref_clk);
        #1;
        chk("out_valid", 32'h1, {31'h0, out_valid});
        @(negedge ref_clk);
        sample_tick = 1'b0;
    endtask : tick
    // --------------------
    // Scenarios
    // --------------------
    task automatic manual_alarms();
        @(negedge ref_clk);
        manual_output = 32'h0000_8000;
        pv_set = 32'h0000_E666;
        tick();
        chk("out", 32'h0000_8000, control_output);
        chk("alarms", 32'h3, {28'h0, alarms[3:0]});
    endtask : manual_alarms
    task automatic bumpless();
        @(negedge ref_clk);
        mode = pid_pkg::MODE_AUTO;
        pv_set = 32'h0000_C7AE;
        tick();
        chk("sp", 32'h0000_C7AE, active_setpoint);
        chk("out", 32'h0000_8000, control_output);
        chk("alarms", 32'h3, {28'h0, alarms[3:0]});
    endtask : bumpless
    task automatic p_reverse();
        @(negedge ref_clk);
        transfer_variant_two = 1'b1;
        setpoint_in = 32'h0000_8000;
        pv_set = 32'h0000_4000;
        tick();
        chk("out", 32'h0000_C000, control_output);
        chk("bias", 32'h0000_8000, bias_term);
        chk("alarms", 32'h1A0, {22'h0, alarms});
        @(negedge ref_clk);
        reverse_acting = 1'b1;
        tick();
        chk("out", 32'h0000_4000, control_output);
        chk("alarms", 32'h0A0, {22'h0, alarms});
    endtask : p_reverse
    task automatic saturate();
        @(negedge ref_clk);
        reverse_acting = 1'b0;
        proportional_gain = 32'h0004_0000;
        freeze_bias = 1'b1;
        tick();
        chk("out", 32'h0001_0000, control_output);
        chk("bias", 32'h0000_8000, bias_term);
        @(negedge ref_clk);
        freeze_bias = 1'b0;
        tick();
        chk("bias", 32'h0, bias_term);
    endtask : saturate
    task automatic shaping();
        @(negedge ref_clk);
        proportional_gain = 32'h0001_0000;
        {error_squared, deadband_en, bias_load} = 3'b111;
        bias_load_value = 32'h0000_8000;
        tick();
        chk("out", 32'h0000_8000, control_output);
        @(negedge ref_clk);
        deadband_en = 1'b0;
        tick();
        chk("out", 32'h0000_9000, control_output);
    endtask : shaping
    task automatic velocity();
        @(negedge ref_clk);
        {error_squared, bias_load} = 2'b00;
        velocity_form = 1'b1;
        integral_time = 16'h0004;
        tick();
        tick();
        chk("delta", 32'h0000_1000, control_output);
    endtask : velocity
    task automatic cascade_refuse();
        @(negedge ref_clk);
        velocity_form = 1'b0;
        integral_time = 16'h270F;
        mode = pid_pkg::MODE_CASCADE;
        cascade_setpoint = 32'h0000_6000;
        tick();
        chk("sp", 32'h0000_6000, active_setpoint);
        @(negedge ref_clk);
        {clk_en, sample_tick} = 2'b01;
        repeat (3) begin
            @(posedge ref_clk);
            #1;
            chk("valid", 32'h0, {31'h0, out_valid});
        end
        @(negedge ref_clk);
        {clk_en, sample_tick} = 2'b10;
    endtask : cascade_refuse
    task automatic special_calc();
        @(negedge ref_clk);
        mode = pid_pkg::MODE_AUTO;
        bias_step = 1'b1;
        tick();
        chk("bias", 32'h0000_AAAA, bias_term);
        @(negedge ref_clk);
        {bias_step, proportional_gain} = {1'b0, 32'h0};
        derivative_time = 16'h0002;
        pv_set = 32'h0000_5000;
        tick();
        chk("out", 32'h0000_8AAA, control_output);
        @(negedge ref_clk);
        derivative_time = 16'h0000;
        pv_set = 32'h0000_6000;
        tick();
        chk("out", 32'h0000_AAAA, control_output);
        @(negedge ref_clk);
        {derivative_time, deriv_limit_en} = {16'h0002, 1'b1};
        pv_set = 32'h0000_9000;
        tick();
        chk("out", 32'h0000_8AAC, control_output);
    endtask : special_calc
    task automatic root_transfer();
        @(negedge ref_clk);
        {deriv_limit_en, derivative_time} = {1'b0, 16'h0000};
        proportional_gain = 32'h0001_0000;
        sqrt_pv = 1'b1;
        pv_set = 32'h0000_4000;
        tick();
        chk("out", 32'h0000_AAAA, control_output);
        @(negedge ref_clk);
        mode = pid_pkg::MODE_MANUAL;
        manual_output = 32'h0000_3000;
        tick();
        @(negedge ref_clk);
        mode = pid_pkg::MODE_AUTO;
        setpoint_in = 32'h0000_A000;
        tick();
        chk("sp", 32'h0000_A000, active_setpoint);
        chk("bias", 32'h0000_3000, bias_term);
        chk("out", 32'h0000_5000, control_output);
    endtask : root_transfer
    initial begin
        {resetn, sample_tick, transfer_variant_two, velocity_form} = '0;
        {reverse_acting, freeze_bias, bias_step, sqrt_pv} = '0;
        {error_squared, deadband_en, deriv_limit_en, bias_load} = '0;
        clk_en = 1'b1;
        mode = pid_pkg::MODE_MANUAL;
        {setpoint_in, cascade_setpoint, manual_output} = '0;
        {bias_load_value, pv_set} = '0;
        proportional_gain = 32'h0001_0000;
        derivative_limit_coefficient = 32'h0001_0000;
        integral_time = 16'h270F;
        derivative_time = 16'h0000;
        sample_period = 16'h0001;
        {limit_hh, limit_h} = {32'h0000_CCCD, 32'h0000_B333};
        {limit_l, limit_ll} = {32'h0000_3333, 32'h0000_199A};
        {dev_first, dev_second} = {32'h0000_199A, 32'h0000_3333};
        {rate_limit, hysteresis} = {32'h0000_8000, 32'h0000_0CCD};
        deadband = 32'h0000_199A;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        manual_alarms();
        bumpless();
        p_reverse();
        saturate();
        shaping();
        velocity();
        cascade_refuse();
        special_calc();
        root_transfer();
        finish_test();
    end
endmodule : pid_loop_compute_tb
bind pid_loop_compute pid_chk chk_u (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(clk_en), .sample_tick(sample_tick), .mode(mode),
    .transfer_variant_two(transfer_variant_two),
    .velocity_form(velocity_form), .sqrt_pv(sqrt_pv),
    .process_value(process_value), .manual_output(manual_output),
    .cascade_setpoint(cascade_setpoint), .limit_hh(limit_hh),
    .hysteresis(hysteresis), .control_output(control_output),
    .active_setpoint(active_setpoint), .out_valid(out_valid),
    .alarms(alarms));
